// file: hl_consts.svh
// Register map, field positions and timing counts of the serial host port.
`ifndef HL_CONSTS_SVH
`define HL_CONSTS_SVH
`define HL_R_RCV_FIFO   5'h01
`define HL_R_SND_FIFO   5'h02
`define HL_R_SUD_FIFO   5'h04
`define HL_R_RCV_BC     5'h06
`define HL_R_SND_BC     5'h07
`define HL_R_CTL_LO     5'h0d
`define HL_R_STICK_LO   5'h14
`define HL_R_CTL_HI     5'h15
`define HL_R_STICK_HI   5'h1f
`define HL_R_PIN_CTL    5'h11
`define HL_R_IRQ        5'h19
`define HL_R_MODE       5'h1b
`define HL_R_PER_ADDR   5'h1c
`define HL_R_HOST_CTL   5'h1d
`define HL_R_LAUNCH     5'h1e
`define HL_R_RESULT     5'h1f
`define HL_B_FDUP       4
`define HL_B_HOST       0
`define HL_B_HS         7
`define HL_B_ISO        6
`define HL_B_OUT_NOT_IN     5
`define HL_B_SETUP      4
`define HL_B_STOG1      3
`define HL_B_STOG0      2
`define HL_B_RTOG1      1
`define HL_B_RTOG0      0
`define HL_IRQ_DONE     7
`define HL_IRQ_SNDBAV   3
`define HL_IRQ_RCVDAV   2
`define HL_IRQ_EXT_MASK 8'h73
`define HL_IRQ_RESET    8'h08
`define HL_RES_SUCCESS  4'h0
`define HL_RES_PENDING  4'h1
`define HL_RES_NAK      4'h4
`define HL_RES_STALL    4'h5
`define HL_T_LAUNCH     0
`define HL_T_HCTL       1
`define HL_T_CLR        2
`define HL_T_BC         3
`define HL_FIFO_DEPTH   64
`define HL_SUD_DEPTH    8
`define HL_SCLK_HALF    3'h4
`endif

// file: hl_pkg.sv
// Types shared by the two ends of the serial host port.
package hl_pkg;
    typedef enum logic [1:0] {
        HL_IDLE  = 2'b00,
        HL_SHIFT = 2'b01,
        HL_DESEL = 2'b11
    } hl_hst_t;
    // Frame state of the device, loaded with is_cmd set and all else clear while select is high.
    typedef struct packed {
        logic       is_cmd;
        logic [2:0] bitcnt;
        logic [6:0] sh;
        logic [4:0] addr;
        logic       wr;
        logic [7:0] out;
    } hl_frm_t;
    // Serial-clocked registers of the device.
    typedef struct packed {
        logic [1:0]  rs;
        logic        fdup;
        logic        host;
        logic        ack;
        logic [6:0]  per_addr;
        logic [6:0]  snd_bc;
        logic [3:0]  hctl;
        logic [7:0]  xfer;
        logic [7:0]  clr;
        logic [3:0]  tg;
        logic [5:0]  snd_wp;
        logic [2:0]  sud_wp;
        logic [5:0]  rcv_rp;
        logic        st1;
        logic        st2;
        logic        stseen;
        logic [7:0]  irq1;
        logic [7:0]  irq2;
        logic [12:0] res;
    } hl_dreg_t;
    // Engine state on the system clock.
    typedef struct packed {
        logic [3:0] t1;
        logic [3:0] t2;
        logic [3:0] tseen;
        logic       pend;
        logic       busy;
        logic [7:0] xfer;
        logic [6:0] paddr;
        logic [6:0] cnt;
        logic       stog;
        logic       rtog;
        logic [3:0] result;
        logic [7:0] irq;
        logic [6:0] rcv_cnt;
        logic       st;
        logic [7:0] rd;
    } hl_eng_t;
    // Serial master state.
    typedef struct packed {
        hl_hst_t    st;
        logic [2:0] div;
        logic       sclk;
        logic       ss_n;
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] rx;
        logic [1:0] ms;
        logic [6:0] left;
        logic       wr;
        logic       first;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic [7:0] stat;
        logic       stat_valid;
        logic       done;
    } hl_host_t;
endpackage : hl_pkg

// file: hl_spi_if.sv
// Serial link between the master and the register port.
`timescale 1ns/100ps
interface hl_spi_if;
    logic sclk;
    logic ss_n;
    logic mosi;
    logic miso;
    modport dev (input sclk, input ss_n, input mosi, output miso);
    modport host (output sclk, output ss_n, output mosi, input miso);
endinterface : hl_spi_if

// file: hl_dev.sv
// Device end: serial register port with host transfer launch and result logic.
`timescale 1ns/100ps
`include "hl_consts.svh"
module hl_dev (
    hl_spi_if.dev       bus,
    input  wire logic   clk,
    input  wire logic   nrst,
    output logic        eng_launch,
    output logic [7:0]  eng_xfer_type,
    output logic [6:0]  eng_periph_addr,
    output logic [6:0]  eng_send_count,
    output logic        eng_data_toggle,
    input  wire logic   eng_sof_due,
    input  wire logic [5:0] eng_rd_idx,
    output logic [7:0]  eng_rd_data,
    input  wire logic   eng_rcv_we,
    input  wire logic [5:0] eng_rcv_idx,
    input  wire logic [7:0] eng_rcv_data,
    input  wire logic [6:0] eng_rcv_count,
    input  wire logic   eng_done,
    input  wire logic [3:0] eng_result,
    input  wire logic [7:0] eng_evt,
    output logic        ack_status
);
    localparam hl_pkg::hl_frm_t FRM_IDLE = '{is_cmd: 1'b1, default: '0};
    localparam hl_pkg::hl_eng_t ENG_RST  = '{irq: `HL_IRQ_RESET, default: '0};

    hl_pkg::hl_frm_t  f_q, f_d;
    hl_pkg::hl_dreg_t p_q, p_d;
    hl_pkg::hl_eng_t  e_q, e_d;
    logic [7:0]       snd_mem [0:`HL_FIFO_DEPTH-1];
    logic [7:0]       sud_mem [0:`HL_SUD_DEPTH-1];
    logic [7:0]       rcv_mem [0:`HL_FIFO_DEPTH-1];
    logic             snd_we;
    logic             sud_we;
    logic             byte_end;
    logic [7:0]       rx_byte;
    logic [4:0]       nxt;
    logic [5:0]       rp_n;
    logic [12:0]      res_word;
    logic [3:0]       t_ev;
    logic [7:0]       irq_set;
    logic [7:0]       irq_clr;

    // Register read decode. The receive FIFO is written on the system clock but
    // software reads it only after the done flag, so it is stable by then.
    function automatic logic [7:0] rd_reg(input logic [4:0] a, input logic [5:0] rp);
        logic [7:0] v;
        v = 8'h00;
        if (a == `HL_R_RCV_FIFO) begin
            v = rcv_mem[rp];
        end else if (a == `HL_R_RCV_BC) begin
            v = {1'b0, p_q.res[6:0]};
        end else if (a == `HL_R_SND_BC) begin
            v = {1'b0, p_q.snd_bc};
        end else if (a == `HL_R_PIN_CTL) begin
            v = {3'h0, p_q.fdup, 4'h0};
        end else if (a == `HL_R_IRQ) begin
            v = p_q.irq2;
        end else if (a == `HL_R_MODE) begin
            v = {7'h00, p_q.host};
        end else if (a == `HL_R_PER_ADDR) begin
            v = {1'b0, p_q.per_addr};
        end else if (a == `HL_R_HOST_CTL) begin
            v = {p_q.hctl, 4'h0};
        end else if (a == `HL_R_LAUNCH) begin
            v = p_q.xfer;
        end else if (a == `HL_R_RESULT) begin
            v = {2'b00, p_q.res[12:7]};
        end
        return v;
    endfunction : rd_reg

    // Address after one byte of a burst; FIFO and low registers hold still.
    function automatic logic [4:0] next_addr(input logic [4:0] a);
        logic [4:0] n;
        n = a;
        if (a >= `HL_R_CTL_LO && a < `HL_R_STICK_LO) begin
            n = a + 5'h01;
        end else if (a >= `HL_R_CTL_HI && a < `HL_R_STICK_HI) begin
            n = a + 5'h01;
        end
        return n;
    endfunction : next_addr

    // Serial side: shift in, decode command and data bytes, and pick up the
    // engine's status through synchronisers.
    always_comb begin
        f_d = f_q;
        p_d = p_q;
        snd_we = 1'b0;
        sud_we = 1'b0;
        rx_byte = {f_q.sh, bus.mosi};
        byte_end = (f_q.bitcnt == 3'h7);
        nxt = next_addr(f_q.addr);
        rp_n = p_q.rcv_rp;
        p_d.rs = {p_q.rs[0], nrst};
        p_d.st1 = e_q.st;
        p_d.st2 = p_q.st1;
        p_d.irq1 = e_q.irq;
        p_d.irq2 = p_q.irq1;
        if (p_q.st2 != p_q.stseen) begin
            p_d.stseen = p_q.st2;
            p_d.res = res_word;
            rp_n = 6'h00;
        end
        f_d.bitcnt = f_q.bitcnt + 3'h1;
        f_d.sh = rx_byte[6:0];
        if (byte_end && f_q.is_cmd) begin
            f_d.is_cmd = 1'b0;
            f_d.addr = rx_byte[7:3];
            f_d.wr = rx_byte[1];
            if (!p_q.host) begin
                p_d.ack = rx_byte[0];
            end
            f_d.out = rd_reg(rx_byte[7:3], rp_n);
        end else if (byte_end) begin
            if (f_q.wr && f_q.addr == `HL_R_SND_FIFO) begin
                snd_we = 1'b1;
                p_d.snd_wp = p_q.snd_wp + 6'h01;
            end else if (f_q.wr && f_q.addr == `HL_R_SUD_FIFO) begin
                sud_we = 1'b1;
                p_d.sud_wp = p_q.sud_wp + 3'h1;
            end else if (f_q.wr && f_q.addr == `HL_R_SND_BC) begin
                p_d.snd_bc = rx_byte[6:0];
                p_d.snd_wp = 6'h00;
                p_d.tg[`HL_T_BC] = ~p_q.tg[`HL_T_BC];
            end else if (f_q.wr && f_q.addr == `HL_R_PIN_CTL) begin
                p_d.fdup = rx_byte[`HL_B_FDUP];
            end else if (f_q.wr && f_q.addr == `HL_R_MODE) begin
                p_d.host = rx_byte[`HL_B_HOST];
            end else if (f_q.wr && f_q.addr == `HL_R_PER_ADDR) begin
                p_d.per_addr = rx_byte[6:0];
            end else if (f_q.wr && f_q.addr == `HL_R_HOST_CTL) begin
                p_d.hctl = rx_byte[7:4];
                p_d.tg[`HL_T_HCTL] = ~p_q.tg[`HL_T_HCTL];
            end else if (f_q.wr && f_q.addr == `HL_R_LAUNCH) begin
                p_d.xfer = rx_byte;
                p_d.sud_wp = 3'h0;
                p_d.tg[`HL_T_LAUNCH] = ~p_q.tg[`HL_T_LAUNCH];
            end else if (f_q.wr && f_q.addr == `HL_R_IRQ) begin
                p_d.clr = rx_byte;
                p_d.tg[`HL_T_CLR] = ~p_q.tg[`HL_T_CLR];
            end else if (!f_q.wr && f_q.addr == `HL_R_RCV_FIFO) begin
                rp_n = rp_n + 6'h01;
            end
            f_d.addr = nxt;
            f_d.out = rd_reg(nxt, rp_n);
        end
        p_d.rcv_rp = rp_n;
        if (!p_q.rs[1]) begin
            p_d = '0;
            p_d.rs = {p_q.rs[0], nrst};
        end
    end

    always_ff @(posedge bus.sclk or posedge bus.ss_n) begin
        if (bus.ss_n) begin
            f_q <= FRM_IDLE;
        end else begin
            f_q <= f_d;
        end
    end

    // Serial-clocked registers; they are cleared through the rs synchroniser while the engine is held in reset.
    always_ff @(posedge bus.sclk) begin
        p_q <= p_d;
    end

    always_ff @(posedge bus.sclk) begin
        if (snd_we) begin
            snd_mem[p_q.snd_wp] <= rx_byte;
        end
        if (sud_we) begin
            sud_mem[p_q.sud_wp] <= rx_byte;
        end
    end

    assign bus.miso = f_q.is_cmd ? (p_q.fdup & p_q.host & p_q.irq2[~f_q.bitcnt])
                                 : f_q.out[~f_q.bitcnt];

    // Engine side. Multi-bit settings are read from the serial registers only
    // after their event toggle has passed two flops, so they are already stable.
    always_comb begin
        e_d = e_q;
        res_word = {e_q.stog, e_q.rtog, e_q.result, e_q.rcv_cnt};
        e_d.t1 = p_q.tg;
        e_d.t2 = e_q.t1;
        e_d.tseen = e_q.t2;
        t_ev = e_q.t2 ^ e_q.tseen;
        irq_set = eng_evt & `HL_IRQ_EXT_MASK;
        irq_clr = t_ev[`HL_T_CLR] ? p_q.clr : 8'h00;
        irq_clr[`HL_IRQ_SNDBAV] = irq_clr[`HL_IRQ_SNDBAV] | t_ev[`HL_T_BC];
        e_d.rd = e_q.xfer[`HL_B_SETUP] ? sud_mem[eng_rd_idx[2:0]] : snd_mem[eng_rd_idx];
        if (t_ev[`HL_T_LAUNCH]) begin
            e_d.xfer = p_q.xfer;
            e_d.paddr = p_q.per_addr;
            e_d.cnt = p_q.snd_bc;
            e_d.pend = 1'b1;
            e_d.busy = 1'b1;
            e_d.result = `HL_RES_PENDING;
            e_d.st = ~e_q.st;
        end
        if (e_q.pend && !eng_sof_due) begin
            e_d.pend = 1'b0;
        end
        if (t_ev[`HL_T_HCTL]) begin
            if (p_q.hctl[`HL_B_STOG1]) begin
                e_d.stog = 1'b1;
            end else if (p_q.hctl[`HL_B_STOG0]) begin
                e_d.stog = 1'b0;
            end
            if (p_q.hctl[`HL_B_RTOG1]) begin
                e_d.rtog = 1'b1;
            end else if (p_q.hctl[`HL_B_RTOG0]) begin
                e_d.rtog = 1'b0;
            end
        end
        if (eng_done && e_q.busy && !e_q.pend) begin
            e_d.busy = 1'b0;
            e_d.result = eng_result;
            e_d.st = ~e_q.st;
            irq_set[`HL_IRQ_DONE] = 1'b1;
            if (!e_q.xfer[`HL_B_OUT_NOT_IN] && !e_q.xfer[`HL_B_HS]) begin
                e_d.rcv_cnt = eng_rcv_count;
            end
            if (eng_result == `HL_RES_SUCCESS && !e_q.xfer[`HL_B_HS]
                    && !e_q.xfer[`HL_B_SETUP] && !e_q.xfer[`HL_B_ISO]) begin
                if (e_q.xfer[`HL_B_OUT_NOT_IN]) begin
                    e_d.stog = ~e_q.stog;
                    irq_set[`HL_IRQ_SNDBAV] = 1'b1;
                end else begin
                    e_d.rtog = ~e_q.rtog;
                    irq_set[`HL_IRQ_RCVDAV] = 1'b1;
                end
            end
        end
        // A flag raised in the cycle it is cleared stays raised.
        e_d.irq = (e_q.irq & ~irq_clr) | irq_set;
        if (!nrst) begin
            e_d = ENG_RST;
        end
    end

    // Engine registers.
    always_ff @(posedge clk) begin
        e_q <= e_d;
    end

    // Receive FIFO filled by the engine.
    always_ff @(posedge clk) begin
        if (eng_rcv_we) begin
            rcv_mem[eng_rcv_idx] <= eng_rcv_data;
        end
    end

    assign eng_launch      = e_q.pend & ~eng_sof_due;
    assign eng_xfer_type   = e_q.xfer;
    assign eng_periph_addr = e_q.paddr;
    assign eng_send_count  = e_q.cnt;
    assign eng_data_toggle = e_q.xfer[`HL_B_OUT_NOT_IN] ? e_q.stog : e_q.rtog;
    assign eng_rd_data     = e_q.rd;
    assign ack_status      = p_q.ack;
endmodule : hl_dev

// file: hl_host.sv
// Host end: serial master that moves command and data bytes for its user.
`timescale 1ns/100ps
`include "hl_consts.svh"
module hl_host (
    hl_spi_if.host      bus,
    input  wire logic   clk,
    input  wire logic   nrst,
    input  wire logic   req_valid,
    output logic        req_ready,
    input  wire logic [4:0] req_addr,
    input  wire logic   req_write,
    input  wire logic [6:0] req_count,
    input  wire logic   wr_valid,
    output logic        wr_ready,
    input  wire logic [7:0] wr_data,
    output logic        rd_valid,
    output logic [7:0]  rd_data,
    output logic        status_valid,
    output logic [7:0]  status_byte,
    output logic        done
);
    hl_pkg::hl_host_t s_q, s_d;
    logic             tick;
    logic             need;

    // Serial clock is divided down from clk; data changes on falling edges and
    // the synchronised input is taken just before each rising edge.
    always_comb begin
        s_d = s_q;
        s_d.ms = {s_q.ms[0], bus.miso};
        s_d.rd_valid = 1'b0;
        s_d.stat_valid = 1'b0;
        s_d.done = 1'b0;
        tick = (s_q.div == `HL_SCLK_HALF - 3'h1);
        need = s_q.wr && s_q.bitcnt == 3'h7;
        wr_ready = (s_q.st == hl_pkg::HL_SHIFT) && tick && s_q.sclk && need && wr_valid;
        req_ready = (s_q.st == hl_pkg::HL_IDLE);
        if (s_q.st != hl_pkg::HL_IDLE) begin
            s_d.div = tick ? 3'h0 : s_q.div + 3'h1;
        end
        case (s_q.st)
            hl_pkg::HL_IDLE: begin
                if (req_valid) begin
                    s_d.sh = {req_addr, 1'b0, req_write, 1'b0};
                    s_d.ss_n = 1'b0;
                    s_d.bitcnt = 3'h0;
                    s_d.div = 3'h0;
                    s_d.left = req_count;
                    s_d.wr = req_write;
                    s_d.first = 1'b1;
                    s_d.st = hl_pkg::HL_SHIFT;
                end
            end
            hl_pkg::HL_SHIFT: begin
                if (tick && !s_q.sclk) begin
                    s_d.sclk = 1'b1;
                    s_d.rx = {s_q.rx[6:0], s_q.ms[1]};
                    if (s_q.bitcnt == 3'h7) begin
                        if (s_q.first) begin
                            s_d.stat = {s_q.rx[6:0], s_q.ms[1]};
                            s_d.stat_valid = 1'b1;
                        end else if (!s_q.wr) begin
                            s_d.rd_data = {s_q.rx[6:0], s_q.ms[1]};
                            s_d.rd_valid = 1'b1;
                        end
                        s_d.first = 1'b0;
                        if (s_q.left == 7'h00) begin
                            s_d.st = hl_pkg::HL_DESEL;
                        end else begin
                            s_d.left = s_q.left - 7'h01;
                        end
                    end
                end else if (tick && need && !wr_valid) begin
                    // Hold the clock high until the next write byte arrives.
                    s_d.div = s_q.div;
                end else if (tick) begin
                    s_d.sclk = 1'b0;
                    s_d.bitcnt = s_q.bitcnt + 3'h1;
                    s_d.sh = need ? wr_data : {s_q.sh[6:0], 1'b0};
                end
            end
            hl_pkg::HL_DESEL: begin
                if (tick && s_q.sclk) begin
                    s_d.sclk = 1'b0;
                end else if (tick) begin
                    s_d.ss_n = 1'b1;
                    s_d.done = 1'b1;
                    s_d.st = hl_pkg::HL_IDLE;
                end
            end
            default: begin
                s_d.st = hl_pkg::HL_IDLE;
            end
        endcase
        if (!nrst) begin
            s_d = '0;
            s_d.ss_n = 1'b1;
        end
    end

    // Master registers.
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign bus.sclk     = s_q.sclk;
    assign bus.ss_n     = s_q.ss_n;
    assign bus.mosi     = s_q.sh[7];
    assign rd_valid     = s_q.rd_valid;
    assign rd_data      = s_q.rd_data;
    assign status_valid = s_q.stat_valid;
    assign status_byte  = s_q.stat;
    assign done         = s_q.done;
endmodule : hl_host

// file: hl_chk_sva.sv
// Wire checks on the serial link between the two ends.
`timescale 1ns/100ps
module hl_chk_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [2:0] rc_q;
    logic       ps_q;
    // Rising link edges modulo eight; a frame may only end on a byte boundary.
    always_ff @(posedge clk) begin
        ps_q <= sclk;
        if (!nrst || ss_n) rc_q <= 3'h0;
        else if (sclk && !ps_q) rc_q <= rc_q + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_IDLE_LOW: assert property (ss_n |-> !sclk)
        else $error("clock high while deselected");
    AST_SEL_SETUP: assert property ($fell(ss_n) |-> !sclk [*3])
        else $error("clock rose too soon after select");
    AST_HIGH_LEN: assert property ($rose(sclk) |-> sclk [*4])
        else $error("clock high phase short");
    AST_LOW_LEN: assert property ($fell(sclk) && !ss_n |-> !sclk [*4])
        else $error("clock low phase short");
    AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
        else $error("mosi moved at or after a rising edge");
    AST_MISO_HOLD: assert property (
        !ss_n && !sclk && !$past(sclk) && !$past(ss_n) |-> $stable(miso))
        else $error("miso moved without a clock edge");
    AST_BYTE_END: assert property ($rose(ss_n) |-> rc_q == 3'h0)
        else $error("frame ended mid byte");
    AST_DESEL_LOW: assert property ($rose(ss_n) |-> !$past(sclk) && !$past(sclk, 3))
        else $error("deselect while clock active");
endmodule : hl_chk_sva

// file: tb_spi_register_port_host_launch.sv
// Testbench joining the host and device ends with a transfer model.
`timescale 1ns/100ps
module tb_spi_register_port_host_launch;
    logic       clk = 1'b0, nrst = 1'b0, nrst_d = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic       wr_valid = 1'b0, sof = 1'b0, e_done = 1'b0, stog = 1'b0, rtog = 1'b0;
    logic [4:0] req_addr = 5'h00;
    logic [6:0] req_count = 7'h00, pa, nb;
    logic [7:0] wr_data = 8'h00, st, cmd_q, wq[$], rq[$], pl[$];
    logic [7:0] fl = 8'h00;
    logic [5:0] rd_idx = 6'h00;
    logic [3:0] e_res = 4'h0;
    wire        req_ready, wr_ready, rd_valid, status_valid, done, e_launch, e_tog;
    wire  [7:0] rd_data, status_byte, e_type, e_rd;
    wire  [6:0] e_pa, e_cnt;
    int         n_errors = 0, compares = 0, seed = 54591, bits = 0, n_launch = 0;
    hl_spi_if bus ();
    hl_host hl_host_inst (.bus(bus), .clk(clk), .nrst(nrst), .req_valid(req_valid),
        .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write),
        .req_count(req_count), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .status_valid(status_valid),
        .status_byte(status_byte), .done(done));
    hl_dev hl_dev_inst (.bus(bus), .clk(clk), .nrst(nrst_d), .eng_launch(e_launch),
        .eng_xfer_type(e_type), .eng_periph_addr(e_pa), .eng_send_count(e_cnt),
        .eng_data_toggle(e_tog), .eng_sof_due(sof), .eng_rd_idx(rd_idx), .eng_rd_data(e_rd),
        .eng_rcv_we(1'b0), .eng_rcv_idx(6'h00), .eng_rcv_data(8'h00), .eng_rcv_count(7'h00),
        .eng_done(e_done), .eng_result(e_res), .eng_evt(8'h00), .ack_status());
    hl_chk_sva hl_chk_sva_inst (.clk(clk), .nrst(nrst), .sclk(bus.sclk), .ss_n(bus.ss_n),
        .mosi(bus.mosi), .miso(bus.miso));
    // System clock.
    always #25 clk = ~clk;
    // Count launch pulses at the edges where the engine would take them.
    always @(posedge clk) begin
        if (e_launch) n_launch++;
    end
    // Rebuild each command byte from the wire, first bit as most significant.
    always @(posedge bus.sclk or posedge bus.ss_n) begin
        if (bus.ss_n) begin
            bits = 0;
        end else if (bits < 8) begin
            cmd_q = {cmd_q[6:0], bus.mosi};
            bits = bits + 1;
        end
    end
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        compares++;
        if (got !== ex) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic tally_and_finish;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // One framed access; write bytes come from wq, read bytes land in rq.
    task automatic xfer(input logic [4:0] a, input logic w, input int n);
        int k;
        int t;
        k = 0;
        rq.delete();
        req_addr = a;
        req_write = w;
        req_count = 7'(n);
        req_valid = 1'b1;
        for (t = 0; t < 99 && !req_ready; t++) step();
        step();
        req_valid = 1'b0;
        for (t = 0; t < 3000 && !done; t++) begin
            wr_valid = w && k < n;
            wr_data = wr_valid ? wq[k] : 8'h00;
            #1;
            if (wr_ready && wr_valid) k++;
            if (status_valid) st = status_byte;
            if (rd_valid) rq.push_back(rd_data);
            step();
        end
        wr_valid = 1'b0;
        chk("done", 8'h01, {7'h00, done});
        chk("cmd", {a, 1'b0, w, 1'b0}, cmd_q);
    endtask : xfer
    // Launch a transfer, play the engine, and check result, flags and toggles.
    task automatic run(input logic [7:0] code, input logic [3:0] res, input logic hold);
        int t;
        int nl;
        nl = n_launch;
        sof = hold;
        wq = '{code};
        xfer(5'h1e, 1'b1, 1);
        for (t = 0; t < 60 && !(e_launch && !sof); t++) begin
            if (sof) chk("held", 8'h00, {7'h00, e_launch});
            if (t == 20) sof = 1'b0;
            step();
        end
        chk("launch", 8'h01, 8'(n_launch - nl));
        chk("type", code, e_type);
        chk("paddr", {1'b0, pa}, {1'b0, e_pa});
        chk("count", {1'b0, nb}, {1'b0, e_cnt});
        chk("tog", {7'h00, code[5] ? stog : rtog}, {7'h00, e_tog});
        // Out packets read the send FIFO, setup packets the setup FIFO.
        for (t = 0; (code[5] || code[4]) && t < nb; t++) begin
            rd_idx = 6'(t);
            step();
            chk("fifo", pl[t], e_rd);
        end
        xfer(5'h1f, 1'b0, 1);
        chk("pending", {2'b00, stog, rtog, 4'h1}, rq[0] & 8'h3f);
        chk("flags", fl, st);
        e_res = res;
        e_done = 1'b1;
        step();
        e_done = 1'b0;
        // Done always raises its flag; only an acknowledged bulk transfer
        // flips its direction's toggle and raises that direction's buffer flag.
        fl[7] = 1'b1;
        if (res == 4'h0 && code[7:6] == 2'b00 && !code[4]) begin
            fl[code[5] ? 3 : 2] = 1'b1;
            if (code[5]) stog = ~stog;
            else rtog = ~rtog;
        end
        xfer(5'h1f, 1'b0, 2);
        chk("result", {2'b00, stog, rtog, res}, rq[0] & 8'h3f);
        chk("stick", {2'b00, stog, rtog, res}, rq[1] & 8'h3f);
    endtask : run
    // Abort a hung run.
    initial begin
        #2500000;
        n_errors++;
        tally_and_finish();
    end
    // Main sequence; the device is held in reset across one access so its link side resets.
    initial begin
        logic [7:0] cd [9] = '{8'h10, 8'h00, 8'h20, 8'h20, 8'h80, 8'ha0, 8'h40, 8'h60, 8'h00};
        logic [3:0] rs [4] = '{4'h0, 4'h4, 4'h5, 4'h0};
        logic [3:0] ep;
        repeat (5) step();
        nrst = 1'b1;
        xfer(5'h00, 1'b0, 1);
        nrst_d = 1'b1;
        xfer(5'h11, 1'b0, 1);
        chk("stat_off", 8'h00, st);
        wq = '{8'h00, 8'h10};
        xfer(5'h10, 1'b1, 2);
        pa = 7'($random(seed));
        wq = '{8'h01, {1'b0, pa}};
        xfer(5'h1b, 1'b1, 2);
        xfer(5'h11, 1'b0, 1);
        chk("fdup", 8'h10, rq[0]);
        chk("stat_irq", 8'h08, st);
        xfer(5'h1c, 1'b0, 1);
        chk("paddr_rd", {1'b0, pa}, rq[0]);
        xfer(5'h03, 1'b0, 1);
        chk("unmapped", 8'h00, rq[0]);
        nb = 7'(1 + $unsigned($random(seed)) % 8);
        for (int i = 0; i < nb; i++) pl.push_back(8'($random(seed)));
        wq = pl;
        xfer(5'h02, 1'b1, nb);
        xfer(5'h04, 1'b1, nb);
        wq = '{{1'b0, nb}};
        xfer(5'h07, 1'b1, 1);
        // The count write has cleared the send flag; now preset the send toggle to one.
        wq = '{8'h80};
        xfer(5'h1d, 1'b1, 1);
        stog = 1'b1;
        for (int i = 0; i < 9; i++) begin
            ep = 4'($random(seed));
            run(cd[i] | ((cd[i][7] || cd[i][4]) ? 8'h00 : {4'h0, ep}),
                rs[$unsigned($random(seed)) % 4], i == 2);
        end
        tally_and_finish();
    end
endmodule : tb_spi_register_port_host_launch
